/* design/scb_channel.sv */
module scb_channel #(
  parameter int         NUM_DESC  = 8,
  parameter logic [7:0] SYNC_CHAR = 8'h16
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // APB register port
  input  wire scb_pkg::scb_apb_req_t apb_req,
  output scb_pkg::scb_apb_rsp_t      apb_rsp,
  // Serial line pins
  input  wire logic                 serial_clk,
  input  wire logic                 rx_data,
  input  wire logic                 carrier_detect,
  output logic                      tx_data,
  // Buffer memory write port
  output scb_pkg::scb_mem_wr_t       mem_wr,
  input  wire logic                 mem_wr_ready,
  // Interrupt request
  output logic                      irq
);

  if (NUM_DESC < 1 || NUM_DESC > 8) begin : g_check
    $error("NUM_DESC must be 1 to 8");
  end

  typedef struct packed {
    scb_pkg::scb_apb_rsp_t         rsp;
    scb_pkg::scb_mem_wr_t          mw;
    logic                          irq;
    logic                          txd;
    logic [2:0]                    sclk_s;
    logic [1:0]                    rxd_s;
    logic [1:0]                    cd_s;
    logic [7:0]                    flags;
    logic [7:0]                    mask;
    logic [1:0]                    mode;
    logic                          rx_en;
    logic                          tx_en;
    logic                          incl;
    logic [15:0]                   max_len;
    scb_pkg::scb_desc_t [NUM_DESC-1:0] desc;
    logic [2:0]                    idx;
    scb_pkg::scb_rx_state_t        rst;
    logic [7:0]                    rsh;
    logic [2:0]                    rbit;
    logic [6:0]                    rfb;
    logic [3:0]                    zrun;
    logic [15:0]                   block_check_sum;
    logic [7:0]                    pbyte;
    logic [3:0]                    pcnt;
    logic                          tready;
    logic                          tunder;
    logic                          tfull;
    logic                          tdone;
    logic [7:0]                    tlen;
    logic [7:0]                    tdat;
    logic [7:0]                    tsh;
    logic [2:0]                    tbit;
    logic [6:0]                    tfb;
  } scb_state_t;

  scb_state_t q;
  scb_state_t next_q;

  logic        rise;
  logic        fall;
  logic        setup;
  logic        wr;
  logic        bit_in;
  logic [7:0]  nb;
  logic [7:0]  set_ev;
  logic [7:0]  clr_ev;
  logic        byte_done;
  logic        close;
  logic        err_ov;
  logic        err_cd;
  logic        hunt;
  logic        commit;
  logic [15:0] base_bcs;
  logic [2:0]  di;

  // ----------------------------------------------------------------
  // Block check accumulation, one byte, LSB first
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int k = 0; k < 8; k++) begin
      if (r[0] ^ d[k]) begin
        r = (r >> 1) ^ scb_pkg::CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // Serial clock edges found from the second and third stages only
  assign rise   = q.sclk_s[1] & ~q.sclk_s[2];
  assign fall   = ~q.sclk_s[1] & q.sclk_s[2];
  assign bit_in = q.rxd_s[1];
  assign nb     = {bit_in, q.rsh[7:1]};
  assign di     = apb_req.paddr[5:3];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q    = q;
    set_ev    = 8'h00;
    clr_ev    = 8'h00;
    byte_done = 1'b0;
    close     = 1'b0;
    err_ov    = 1'b0;
    err_cd    = 1'b0;
    hunt      = 1'b0;
    setup     = apb_req.psel & ~apb_req.penable;
    wr        = apb_req.psel & apb_req.penable & q.rsp.pready & apb_req.pwrite & ~q.rsp.pslverr;
    commit    = rise & (q.pcnt == 4'h1) & q.incl & (q.mode == scb_pkg::MODE_BISYNC);
    base_bcs  = commit ? crc_byte(q.block_check_sum, q.pbyte) : q.block_check_sum;

    // Two-stage synchronisers; the third clock stage feeds edge finding
    next_q.sclk_s = {q.sclk_s[1:0], serial_clk};
    next_q.rxd_s  = {q.rxd_s[0], rx_data};
    next_q.cd_s   = {q.cd_s[0], carrier_detect};

    // APB: read data captured in setup, so the access phase is one cycle
    next_q.rsp.pready  = setup;
    next_q.rsp.pslverr = 1'b0;
    if (setup) begin
      next_q.rsp.prdata = 32'h0000_0000;
      if (apb_req.paddr == scb_pkg::ADDR_EVENT_FLAGS) begin
        next_q.rsp.prdata[7:0] = q.flags;
      end else if (apb_req.paddr == scb_pkg::ADDR_EVENT_MASK) begin
        next_q.rsp.prdata[7:0] = q.mask;
      end else if (apb_req.paddr == scb_pkg::ADDR_CONTROL) begin
        next_q.rsp.prdata[4:0] = {q.incl, q.tx_en, q.rx_en, q.mode};
      end else if (apb_req.paddr == scb_pkg::ADDR_MAX_RX_LEN) begin
        next_q.rsp.prdata[15:0] = q.max_len;
      end else if (apb_req.paddr == scb_pkg::ADDR_STATUS) begin
        next_q.rsp.prdata = {q.block_check_sum, 5'h00, q.rst, 5'h00, q.idx};
      end else if (apb_req.paddr == scb_pkg::ADDR_TX_CTRL) begin
        next_q.rsp.prdata[15:0] = {q.tready, q.tunder, 6'h00, q.tlen};
      end else if (apb_req.paddr == scb_pkg::ADDR_TX_DATA) begin
        next_q.rsp.prdata[8:0] = {q.tfull, q.tdat};
      end else if (apb_req.paddr[7:6] == scb_pkg::DESC_REGION && apb_req.paddr[1:0] == 2'h0
                   && 32'(di) < NUM_DESC) begin
        if (apb_req.paddr[2]) begin
          next_q.rsp.prdata[23:0] = q.desc[di].ptr;
        end else begin
          next_q.rsp.prdata = {q.desc[di].len, q.desc[di].vacant_slot, q.desc[di].off_chip_buf,
                               q.desc[di].final_slot, 10'h000, q.desc[di].carrier_lost_flag,
                               q.desc[di].rx_lost_data_flag, q.desc[di].check_error_flag};
        end
      end else begin
        next_q.rsp.pslverr = 1'b1; // Unmapped address
      end
    end

    // Register writes take effect at the completing access edge
    if (wr) begin
      if (apb_req.paddr == scb_pkg::ADDR_EVENT_FLAGS) begin
        clr_ev = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == scb_pkg::ADDR_EVENT_MASK) begin
        next_q.mask = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == scb_pkg::ADDR_CONTROL) begin
        next_q.mode  = apb_req.pwdata[1:0];
        next_q.rx_en = apb_req.pwdata[scb_pkg::CTL_RX_EN];
        next_q.tx_en = apb_req.pwdata[scb_pkg::CTL_TX_EN];
        next_q.incl  = apb_req.pwdata[scb_pkg::CTL_INCLUDE];
        if (apb_req.pwdata[scb_pkg::CTL_HUNT]) begin
          hunt  = 1'b1;
          close = (q.rst == scb_pkg::RX_DATA);
        end
        if (apb_req.pwdata[scb_pkg::CTL_BCS_CLR]) begin
          next_q.block_check_sum  = 16'h0000;
          next_q.pcnt = 4'h0;
        end
      end else if (apb_req.paddr == scb_pkg::ADDR_MAX_RX_LEN) begin
        next_q.max_len = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == scb_pkg::ADDR_TX_CTRL) begin
        next_q.tready = apb_req.pwdata[scb_pkg::TX_READY];
        next_q.tunder = apb_req.pwdata[scb_pkg::TX_UNDER];
        next_q.tlen   = apb_req.pwdata[7:0];
        next_q.tdone  = 1'b0;
      end else if (apb_req.paddr == scb_pkg::ADDR_TX_DATA) begin
        next_q.tdat  = apb_req.pwdata[7:0];
        next_q.tfull = 1'b1;
      end else if (apb_req.paddr[7:6] == scb_pkg::DESC_REGION && apb_req.paddr[2]) begin
        next_q.desc[di].ptr = apb_req.pwdata[23:0];
      end else if (apb_req.paddr[7:6] == scb_pkg::DESC_REGION) begin
        next_q.desc[di].len               = apb_req.pwdata[31:16];
        next_q.desc[di].vacant_slot       = apb_req.pwdata[scb_pkg::D_VACANT];
        next_q.desc[di].off_chip_buf      = apb_req.pwdata[scb_pkg::D_OFF_CHIP];
        next_q.desc[di].final_slot        = apb_req.pwdata[scb_pkg::D_FINAL];
        next_q.desc[di].carrier_lost_flag = apb_req.pwdata[scb_pkg::D_CARRIER];
        next_q.desc[di].rx_lost_data_flag = apb_req.pwdata[scb_pkg::D_LOST];
        next_q.desc[di].check_error_flag  = apb_req.pwdata[scb_pkg::D_CHECK];
      end
    end

    // Memory port drains; a byte finished while it is still busy is an overrun
    if (q.mw.valid & mem_wr_ready) begin
      next_q.mw.valid = 1'b0;
    end

    // Deferred inclusion window: the host may still pull the byte out
    if (rise && q.pcnt != 4'h0) begin
      next_q.pcnt = q.pcnt - 4'h1;
      next_q.block_check_sum  = base_bcs;
    end

    // Receiver: bits sampled on rising serial clock
    if (!q.rx_en) begin
      next_q.rst = scb_pkg::RX_OFF;
    end else if (rise) begin
      case (q.rst)
        scb_pkg::RX_OFF: begin
          next_q.rst  = scb_pkg::RX_HUNT;
          next_q.zrun = 4'h0;
        end
        scb_pkg::RX_HUNT: begin
          next_q.rsh  = nb;
          next_q.rbit = 3'h0;
          if (q.cd_s[1]) begin
            if (q.mode == scb_pkg::MODE_TRANSPARENT) begin
              next_q.rst = scb_pkg::RX_DATA;
            end else if (q.mode == scb_pkg::MODE_BISYNC) begin
              if (nb == SYNC_CHAR) begin
                next_q.rst = scb_pkg::RX_DATA;
              end
            end else if (bit_in) begin
              next_q.zrun = 4'h0;
            end else if (q.zrun == scb_pkg::V110_SYNC_ZEROS - 4'h1) begin
              next_q.rst = scb_pkg::RX_DATA;
              next_q.rfb = 7'(scb_pkg::V110_SYNC_ZEROS);
            end else begin
              next_q.zrun = q.zrun + 4'h1;
            end
          end
        end
        scb_pkg::RX_DATA: begin
          if (!q.cd_s[1]) begin
            err_cd = 1'b1;
            hunt   = 1'b1;
          end else begin
            next_q.rsh  = nb;
            next_q.rbit = q.rbit + 3'h1;
            byte_done   = (q.rbit == 3'h7);
            if (q.mode == scb_pkg::MODE_V110) begin
              if (q.rfb == scb_pkg::FRAME_LAST_BIT) begin
                set_ev[scb_pkg::EV_FRAME] = 1'b1;
                next_q.rfb = 7'h00;
              end else begin
                next_q.rfb = q.rfb + 7'h01;
              end
            end
          end
        end
        default: begin
          next_q.rst = scb_pkg::RX_OFF;
        end
      endcase
    end

    // Byte store into the active descriptor's buffer
    if (byte_done) begin
      if (q.mw.valid & ~mem_wr_ready) begin
        err_ov = 1'b1;
        close  = 1'b1;
      end else if (!q.desc[q.idx].vacant_slot) begin
        set_ev[scb_pkg::EV_NO_BUF] = 1'b1;
        hunt = 1'b1;
      end else begin
        next_q.mw.valid    = 1'b1;
        next_q.mw.off_chip = q.desc[q.idx].off_chip_buf;
        next_q.mw.addr     = q.desc[q.idx].ptr + {8'h00, q.desc[q.idx].len};
        next_q.mw.data     = nb;
        next_q.desc[q.idx].len = q.desc[q.idx].len + 16'h0001;
        if (q.mode == scb_pkg::MODE_BISYNC) begin
          next_q.desc[q.idx].check_error_flag = (crc_byte(base_bcs, nb) != 16'h0000);
        end
        next_q.pbyte = nb;
        next_q.pcnt  = scb_pkg::CHECK_WINDOW_SCLK;
        close = (q.desc[q.idx].len + 16'h0001 >= q.max_len);
      end
    end

    // Buffer close: hand back to host and step to the next slot
    if (close | err_cd) begin
      if (q.desc[q.idx].vacant_slot) begin
        next_q.desc[q.idx].vacant_slot = 1'b0;
        if (err_ov) begin
          next_q.desc[q.idx].rx_lost_data_flag = 1'b1;
        end
        if (err_cd) begin
          next_q.desc[q.idx].carrier_lost_flag = 1'b1;
        end
        if (q.desc[q.idx].final_slot || 32'(q.idx) == NUM_DESC - 1) begin
          next_q.idx = 3'h0;
        end else begin
          next_q.idx = q.idx + 3'h1;
        end
        if (q.mode != scb_pkg::MODE_V110) begin
          set_ev[scb_pkg::EV_RX_BUF] = 1'b1;
        end
      end
    end

    // Hunt restarts character alignment and the block check
    if (hunt && q.rst != scb_pkg::RX_OFF) begin
      next_q.rst  = scb_pkg::RX_HUNT;
      next_q.zrun = 4'h0;
      next_q.rbit = 3'h0;
      next_q.block_check_sum  = 16'h0000;
      next_q.pcnt = 4'h0;
    end

    // Transmitter: bits shift out on falling serial clock, LSB first
    if (q.tx_en && fall) begin
      next_q.txd  = q.tsh[0];
      next_q.tsh  = {1'b1, q.tsh[7:1]};
      next_q.tbit = q.tbit + 3'h1;
      next_q.tfb  = (q.tfb == scb_pkg::FRAME_LAST_BIT) ? 7'h00 : q.tfb + 7'h01;
      if (q.tdone && (q.mode != scb_pkg::MODE_V110 || q.tfb == scb_pkg::TX_SENT_BIT)) begin
        set_ev[scb_pkg::EV_TX_BUF] = 1'b1;
        next_q.tready = 1'b0;
        next_q.tdone  = 1'b0;
      end
      if (q.tbit == 3'h7 && q.tready && !q.tdone) begin
        if (q.tlen == 8'h00) begin
          next_q.tdone = 1'b1;
        end else if (q.tfull) begin
          next_q.tsh   = q.tdat;
          next_q.tfull = 1'b0;
          next_q.tlen  = q.tlen - 8'h01;
        end else begin
          set_ev[scb_pkg::EV_UNDERRUN] = 1'b1;
          next_q.tunder = 1'b1;
          next_q.tready = 1'b0;
        end
      end
    end else if (!q.tx_en) begin
      next_q.txd  = 1'b1;
      next_q.tbit = 3'h0;
      next_q.tfb  = 7'h00;
    end

    // Events: a set in the same cycle as its clear wins
    next_q.flags = (q.flags & ~clr_ev) | set_ev;
    next_q.irq   = |(next_q.flags & next_q.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q       <= '0;
      q.rst   <= scb_pkg::RX_OFF;
      q.txd   <= 1'b1;
      q.flags <= scb_pkg::FLAGS_RESET;
      q.mask  <= scb_pkg::MASK_RESET;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from the state register
  assign apb_rsp = q.rsp;
  assign mem_wr  = q.mw;
  assign tx_data = q.txd;
  assign irq     = q.irq;

endmodule

/* design/scb_pkg.sv */
package scb_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_EVENT_MASK  = 8'h04;
  localparam logic [7:0] ADDR_CONTROL     = 8'h08;
  localparam logic [7:0] ADDR_MAX_RX_LEN  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS      = 8'h10;
  localparam logic [7:0] ADDR_TX_CTRL     = 8'h14;
  localparam logic [7:0] ADDR_TX_DATA     = 8'h18;
  localparam logic [1:0] DESC_REGION      = 2'h1;   // paddr[7:6]: descriptors at 0x40..0x7c

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int EV_RX_BUF   = 0;
  localparam int EV_TX_BUF   = 1;
  localparam int EV_NO_BUF   = 2;
  localparam int EV_FRAME    = 3;
  localparam int EV_UNDERRUN = 4;
  localparam int CTL_RX_EN   = 2;
  localparam int CTL_TX_EN   = 3;
  localparam int CTL_INCLUDE = 4;
  localparam int CTL_HUNT    = 5;
  localparam int CTL_BCS_CLR = 6;
  localparam int D_VACANT    = 15;
  localparam int D_OFF_CHIP  = 14;
  localparam int D_FINAL     = 13;
  localparam int D_CARRIER   = 2;
  localparam int D_LOST      = 1;
  localparam int D_CHECK     = 0;
  localparam int TX_READY    = 15;
  localparam int TX_UNDER    = 14;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [7:0]  MASK_RESET  = 8'h00;
  localparam logic [15:0] CRC_POLY    = 16'ha001;

  // ----------------------------------------------------------------
  // Modes, timing counts, states
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_TRANSPARENT = 2'h0;
  localparam logic [1:0] MODE_BISYNC      = 2'h1;
  localparam logic [1:0] MODE_V110        = 2'h2;
  localparam logic [3:0] CHECK_WINDOW_SCLK = 4'h8;
  localparam logic [6:0] FRAME_LAST_BIT    = 7'h4f;  // 80-bit frame, bits 0..79
  localparam logic [6:0] TX_SENT_BIT       = 7'h4e;  // second to last bit
  localparam logic [3:0] V110_SYNC_ZEROS   = 4'h8;

  typedef enum logic [2:0] {
    RX_OFF  = 3'b001,
    RX_HUNT = 3'b010,
    RX_DATA = 3'b100
  } scb_rx_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } scb_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } scb_apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        off_chip;
    logic [23:0] addr;
    logic [7:0]  data;
  } scb_mem_wr_t;

  typedef struct packed {
    logic        vacant_slot;
    logic        off_chip_buf;
    logic        final_slot;
    logic        carrier_lost_flag;
    logic        rx_lost_data_flag;
    logic        check_error_flag;
    logic [15:0] len;
    logic [23:0] ptr;
  } scb_desc_t;

endpackage

/* sim/scb_channel_assertions.sv */
module scb_channel_assertions (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset,
  // Register port
  input wire scb_pkg::scb_apb_req_t apb_req,
  input wire scb_pkg::scb_apb_rsp_t apb_rsp,
  // Serial pins
  input wire logic                  serial_clk,
  input wire logic                  rx_data,
  input wire logic                  carrier_detect,
  input wire logic                  tx_data,
  // Memory port and interrupt
  input wire scb_pkg::scb_mem_wr_t  mem_wr,
  input wire logic                  mem_wr_ready,
  input wire logic                  irq
);
  // ----------------------------------------
  // Register port, memory port and interrupt checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Setup phase and completed access
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_done;
    apb_req.psel && apb_req.penable && apb_rsp.pready;
  endsequence
  sequence s_read(logic [7:0] a);
    s_done ##0 (!apb_req.pwrite && apb_req.paddr == a);
  endsequence

  a_setup_answer: assert property (s_setup |=> apb_rsp.pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  a_bad_addr: assert property (s_setup ##0 (apb_req.paddr == 8'h20) |=> apb_rsp.pready && apb_rsp.pslverr)
    else $error("unmapped access not refused");
  a_mem_hold: assert property (mem_wr.valid && !mem_wr_ready |=> mem_wr.valid && $stable(mem_wr))
    else $error("memory write dropped before accept");
  a_mask_width: assert property (s_read(scb_pkg::ADDR_EVENT_MASK) |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("mask wider than eight bits");
  a_flags_width: assert property (s_read(scb_pkg::ADDR_EVENT_FLAGS) |-> apb_rsp.prdata[31:5] == 27'h0)
    else $error("event bits outside layout");
  a_ptr_upper: assert property (s_done ##0 (!apb_req.pwrite && apb_req.paddr[7:6] == scb_pkg::DESC_REGION
    && apb_req.paddr[2]) |-> apb_rsp.prdata[31:24] == 8'h0)
    else $error("pointer upper byte not zero");
  a_state_onehot: assert property (s_read(scb_pkg::ADDR_STATUS) |-> $onehot(apb_rsp.prdata[10:8]))
    else $error("receive state not one-hot");
  a_mask_off_irq: assert property (s_done ##0 (apb_req.pwrite && apb_req.paddr == scb_pkg::ADDR_EVENT_MASK
    && apb_req.pwdata[7:0] == 8'h0) |-> ##2 !irq)
    else $error("interrupt kept with all masked");
endmodule

/* sim/scb_line_peer.sv */
module scb_line_peer (
  // System side
  input wire logic                 clk,
  input wire scb_pkg::scb_mem_wr_t mem_wr,
  output logic                     mem_wr_ready,
  // Line side
  output logic                     serial_clk,
  output logic                     rx_data,
  output logic                     carrier_detect
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Line peer and buffer memory
  // ----------------------------------------
  logic [32:0] got_q[$];
  logic        stall;

  initial begin
    serial_clk = 1'b0;
    rx_data = 1'b1;
    carrier_detect = 1'b1;
    stall = 1'b0;
    mem_wr_ready = 1'b0;
  end

  // Memory takes writes at random moments, so slow memory is exercised too
  always @(posedge clk) begin
    if (mem_wr.valid && mem_wr_ready)
      got_q.push_back({mem_wr.off_chip, mem_wr.addr, mem_wr.data});
    mem_wr_ready <= !stall && ($urandom_range(1, 0) == 1);
  end

  // Bits go out first bit lowest; the clock stops low between frames
  task automatic send_bits(input logic [7:0] b, input int n);
    #13;
    for (int i = 0; i < n; i++) begin
      rx_data = b[i];
      #200 serial_clk = 1'b1;
      #200 serial_clk = 1'b0;
    end
    rx_data = ~rx_data; // Released line must not look like held data
  endtask
endmodule

/* sim/tb_scb_channel.sv */
module tb_scb_channel;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Bench signals and instances
  // ----------------------------------------
  logic                  clk, reset, serial_clk, rx_data, carrier_detect, tx_data, mem_wr_ready, irq;
  scb_pkg::scb_apb_req_t apb_req;
  scb_pkg::scb_apb_rsp_t apb_rsp;
  scb_pkg::scb_mem_wr_t  mem_wr;
  int                    err_total, tests_run;
  logic [39:0]           exp_q[$];

  scb_channel dut_u (.clk, .reset, .apb_req, .apb_rsp, .serial_clk, .rx_data, .carrier_detect,
    .tx_data, .mem_wr, .mem_wr_ready, .irq);
  scb_line_peer peer_u (.clk, .mem_wr, .mem_wr_ready, .serial_clk, .rx_data, .carrier_detect);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] x, input logic [39:0] g);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask

  // One APB transfer; request held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk("register", {8'h0, x}, {8'h0, r & m});
  endtask

  // Polls until a settled value appears; a spent bound ends the run
  task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0, r, e);
      n++;
    end while ((r & m) !== x && n < 200);
    chk("polled", {8'h0, x}, {8'h0, r & m});
    if ((r & m) !== x) complete_run();
  endtask

  task automatic desc(input int i, input logic [31:0] w0, input logic [23:0] p);
    wr(8'(8'h40 + 8 * i), w0);
    wr(8'(8'h44 + 8 * i), {8'h0, p});
  endtask

  // Two random bytes fill one buffer; a hunting receiver drops its first bit
  task automatic fill(input logic [23:0] p, input logic o);
    logic [31:0] s;
    logic [7:0]  b;
    logic        e;
    int          n;
    apb(1'b0, scb_pkg::ADDR_STATUS, 32'h0, s, e);
    // An idle receiver spends one edge waking up, a hunting one one more to align
    if (s[10:8] == 3'b001) peer_u.send_bits(8'h00, 2);
    if (s[10:8] == 3'b010) peer_u.send_bits(8'h00, 1);
    for (int k = 0; k < 2; k++) begin
      b = 8'($urandom);
      exp_q.push_back({7'h0, o, p + 24'(k), b});
      peer_u.send_bits(b, 8);
    end
    n = 0;
    while (peer_u.got_q.size() < exp_q.size() && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) begin
      err_total++;
      complete_run();
    end
  endtask

  // Reference block check: reflected polynomial, lowest bit first, from zero
  function automatic logic [15:0] bcs_model(input logic [15:0] c, input logic [7:0] d);
    for (int k = 0; k < 8; k++) begin
      c = (c[0] ^ d[k]) ? ((c >> 1) ^ scb_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] m;
    logic [31:0] r;
    logic        e;
    logic [23:0] p0, p1;
    logic [7:0]  tb_byte, tx_got;
    logic [15:0] c16;
    void'($urandom(64));
    apb_req = '0;
    reset = 1'b1;
    err_total = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rdc(scb_pkg::ADDR_EVENT_FLAGS, 32'hff, 32'(scb_pkg::FLAGS_RESET));
    rdc(scb_pkg::ADDR_EVENT_MASK, 32'hff, 32'(scb_pkg::MASK_RESET));
    m = $urandom;
    wr(scb_pkg::ADDR_EVENT_MASK, m);
    rdc(scb_pkg::ADDR_EVENT_MASK, 32'hffff_ffff, {24'h0, m[7:0]});
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("refusal", 40'h1, {39'h0, e});
    wr(scb_pkg::ADDR_EVENT_MASK, 32'h1);
    wr(scb_pkg::ADDR_MAX_RX_LEN, 32'h2);
    p0 = {8'h0, 16'($urandom)};
    p1 = {8'h0, 16'($urandom)};
    desc(0, 32'h8000, p0);
    desc(1, 32'he000, p1);
    wr(scb_pkg::ADDR_CONTROL, 32'h4);
    fill(p0, 1'b0);
    rdc(8'h40, 32'hffff_e007, 32'h0002_0000);
    rdc(8'h44, 32'hffff_ffff, {8'h0, p0});
    rdc(scb_pkg::ADDR_EVENT_FLAGS, 32'h1, 32'h1);
    chk("irq", 40'h1, {39'h0, irq});
    wr(scb_pkg::ADDR_EVENT_FLAGS, 32'h0);
    rdc(scb_pkg::ADDR_EVENT_FLAGS, 32'h1, 32'h1);
    wr(scb_pkg::ADDR_EVENT_FLAGS, 32'hff);
    rdc(scb_pkg::ADDR_EVENT_FLAGS, 32'hff, 32'h0);
    chk("irq", 40'h0, {39'h0, irq});
    fill(p1, 1'b1);
    rdc(8'h48, 32'hffff_e007, 32'h0002_6000);
    wait_reg(scb_pkg::ADDR_STATUS, 32'h7, 32'h0);
    // Carrier falls while receiving: buffer closes with the carrier flag
    desc(0, 32'h8000, p0);
    peer_u.carrier_detect <= 1'b0;
    peer_u.send_bits(8'h00, 2);
    wait_reg(scb_pkg::ADDR_STATUS, 32'h7, 32'h1);
    rdc(8'h40, 32'h8004, 32'h0004);
    peer_u.carrier_detect <= 1'b1;
    // Rate adaption with no free descriptor: byte dropped, busy event
    wr(scb_pkg::ADDR_CONTROL, 32'h6);
    peer_u.send_bits(8'h00, 8);
    peer_u.send_bits(8'($urandom), 8);
    wait_reg(scb_pkg::ADDR_EVENT_FLAGS, 32'h4, 32'h4);
    wr(scb_pkg::ADDR_EVENT_MASK, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq", 40'h0, {39'h0, irq});
    // Transmit one byte: loaded on the eighth fall, shifted out on the next eight
    tb_byte = 8'($urandom);
    wr(scb_pkg::ADDR_TX_DATA, {24'h0, tb_byte});
    wr(scb_pkg::ADDR_TX_CTRL, 32'h8001);
    wr(scb_pkg::ADDR_CONTROL, 32'h8);
    for (int k = 0; k < 17; k++) begin
      peer_u.send_bits(8'h00, 1);
      repeat (5) @(posedge clk);
      if (k >= 8 && k < 16) tx_got[k - 8] = tx_data;
    end
    chk("tx byte", {32'h0, tb_byte}, {32'h0, tx_got});
    rdc(scb_pkg::ADDR_TX_CTRL, 32'h8000, 32'h0);
    rdc(scb_pkg::ADDR_EVENT_FLAGS, 32'h2, 32'h2);
    // Byte-synchronous receive: check error carries the running block check
    desc(1, 32'h8000, p1);
    wr(scb_pkg::ADDR_CONTROL, 32'h55);
    peer_u.send_bits(8'h00, 8);
    peer_u.send_bits(8'h16, 8);
    fill(p1, 1'b0);
    c16 = bcs_model(bcs_model(16'h0, exp_q[4][7:0]), exp_q[5][7:0]);
    rdc(8'h48, 32'hffff_0001, {16'h2, 15'h0, c16 != 16'h0});
    chk("bytes", 40'(exp_q.size()), 40'(peer_u.got_q.size()));
    foreach (exp_q[i]) chk("byte", exp_q[i], {7'h0, peer_u.got_q[i]});
    complete_run();
  end
endmodule

bind scb_channel scb_channel_assertions chk_u (.clk, .reset, .apb_req, .apb_rsp, .serial_clk, .rx_data,
  .carrier_detect, .tx_data, .mem_wr, .mem_wr_ready, .irq);
